// [rtl/sps_pkg.sv]
// constants for the strap-selected serial port and its two-wire slave
package sps_pkg;
    // fixed upper bits of the seven-bit slave address
    localparam logic [3:0] SLV_ADDR_MSB = 4'hB;
    localparam int SLV_ADDR_BITS = 7;
    // three-level strap codes as delivered by the pad sensor
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_OPEN = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [2:0] LVL_RADIX = 3'h3;
    // direction bit values after the slave address
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    // byte framing
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [1:0] IDX_SLAVE = 2'h0;
    localparam logic [1:0] IDX_ADDR_HI = 2'h1;
    localparam logic [1:0] IDX_ADDR_LO = 2'h2;
    localparam logic [1:0] IDX_DATA = 2'h3;
    // register address and data widths
    localparam int REG_AW = 16;
    localparam int REG_DW = 8;
    localparam logic [15:0] ADDR_STEP = 16'h0001;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    // bus timing: fastest bus period against the sampling clock
    localparam int CLK_PERIOD_NS = 10;
    localparam int STD_RATE_KHZ = 100;
    localparam int FAST_RATE_KHZ = 400;
    localparam int FAST_PERIOD_NS = 1000000 / FAST_RATE_KHZ;
    localparam int FAST_PERIOD_CYC = FAST_PERIOD_NS / CLK_PERIOD_NS;
    // synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 3;
    // slave protocol states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_RACK,
        ST_WAIT
    } sps_state_t;
endpackage

// [rtl/sps_wbuf.sv]
// two-entry buffer between the slave and the register write port
`timescale 1ns/100ps
module sps_wbuf #(
    parameter int WIDTH = 24
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] tail_reg;
    logic tail_v_reg;
    logic push;
    logic pop;

    // transfer strobes on both sides
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign in_ready = ~tail_v_reg;

    // head entry drives the output, tail catches a word during a stall
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            out_valid <= 1'b0;
            out_data <= '0;
            tail_v_reg <= 1'b0;
            tail_reg <= '0;
        end
        else if (pop)
        begin
            if (tail_v_reg)
            begin
                out_data <= tail_reg;
                tail_v_reg <= push;
                tail_reg <= in_data;
            end
            else
            begin
                out_valid <= push;
                out_data <= in_data;
            end
        end
        else if (push)
        begin
            if (!out_valid)
            begin
                out_valid <= 1'b1;
                out_data <= in_data;
            end
            else
            begin
                tail_v_reg <= 1'b1;
                tail_reg <= in_data;
            end
        end
    end
endmodule

// [rtl/sps_serial_port.sv]
// strap-selected serial port front end with two-wire register slave
//
// Operation
// - SPI only when both strap pins read high; else the two-wire slave.
// - Slave address is seven bits, upper four fixed at 1011.
// - Low three address bits come from the two three-level straps.
// - Works at 100 kHz and 400 kHz bus rates.
// - Device is a pure slave and never drives the clock line.
// - Register address is two bytes, sixteen bits.
// - Data line changes only while clock is low.
// - Falling data with clock high starts a transfer.
// - Rising data with clock high ends a transfer.
// - Bytes are eight bits, MSB first, then an acknowledge bit.
// - Receiver pulls data low on ninth clock to acknowledge.
// - Receiver leaves data high on ninth clock to refuse.
// - Port keeps working while the chip sleeps.
// - Every configuration register can be read and written.
// - Direction bit 0 writes, 1 reads.
// - Write: address high byte, low byte, then data bytes.
// - Start or stop anywhere discards a partial byte.
// - Master refuses last read byte; device then releases data line.
`timescale 1ns/100ps
module sps_serial_port
    import sps_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // two-wire bus pins, data line open drain
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    // strap pins as three-level codes, and sleep pin
    input wire logic [1:0] PORT_SELECT_UPPER,
    input wire logic [1:0] PORT_SELECT_LOWER,
    input wire logic CHIP_SLEEP_N,
    // mode status
    output logic SPI_SELECT,
    output logic [2:0] SLAVE_OFFSET,
    // register write port
    output logic REG_WR_VALID,
    input wire logic REG_WR_READY,
    output logic [15:0] REG_WR_ADDR,
    output logic [7:0] REG_WR_DATA,
    // register read port
    output logic REG_RD_REQ,
    output logic [15:0] REG_RD_ADDR,
    input wire logic REG_RD_VALID,
    input wire logic [7:0] REG_RD_DATA
);
    localparam int SW = 6;

    // strap digit of one three-level pin
    function automatic logic [2:0] lvl_digit(input logic [1:0] lvl);
        if (lvl == LVL_HIGH)
            return 3'h2;
        else if (lvl == LVL_LOW)
            return 3'h0;
        else
            return 3'h1;
    endfunction

    logic [SW-1:0] s1_reg;
    logic [SW-1:0] s2_reg;
    logic [SW-1:0] s3_reg;
    logic [SW-1:0] filt_reg;
    logic [SW-1:0] filt_next;
    logic [SW-1:0] agree;
    logic scl_f;
    logic sda_f;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic strap_done_reg;
    logic [1:0] strap_cnt_reg;
    logic [2:0] offset_next;
    sps_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] sh_reg;
    logic [1:0] idx_reg;
    logic rw_reg;
    logic [15:0] addr_reg;
    logic [7:0] rd_reg;
    logic [7:0] tx_reg;
    logic wr_push;
    logic wr_ready;
    logic [6:0] own_addr;
    logic byte_done;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers, a change counts once stages two and three agree
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            s1_reg <= '1;
            s2_reg <= '1;
            s3_reg <= '1;
            filt_reg <= '1;
        end
        else
        begin
            s1_reg <= {SCL_IN, SDA_IN, PORT_SELECT_UPPER, PORT_SELECT_LOWER};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            filt_reg <= filt_next;
        end
    end

    // filtered values and bus events
    assign agree = ~(s2_reg ^ s3_reg);
    assign filt_next = (s3_reg & agree) | (filt_reg & ~agree);
    assign scl_f = filt_reg[5];
    assign sda_f = filt_reg[4];
    assign scl_rise = ~scl_f & filt_next[5];
    assign scl_fall = scl_f & ~filt_next[5];
    assign start_ev = scl_f & filt_next[5] & sda_f & ~filt_next[4];
    assign stop_ev = scl_f & filt_next[5] & ~sda_f & filt_next[4];

    ////////////////////////////////////////////////////////////////////////
    // strap capture once the pin stages have filled after reset release
    assign offset_next = 3'((lvl_digit(filt_next[3:2]) * LVL_RADIX)
        + lvl_digit(filt_next[1:0]));
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            strap_cnt_reg <= 2'h0;
            strap_done_reg <= 1'b0;
            SPI_SELECT <= 1'b0;
            SLAVE_OFFSET <= 3'h0;
        end
        else if (strap_cnt_reg != 2'(SYNC_STAGES))
            strap_cnt_reg <= strap_cnt_reg + 2'h1; // reset values must not be taken
        else if (!strap_done_reg && (&agree[3:0]))
        begin
            strap_done_reg <= 1'b1;
            SPI_SELECT <= (filt_next[3:2] == LVL_HIGH)
                && (filt_next[1:0] == LVL_HIGH);
            SLAVE_OFFSET <= offset_next;
        end
    end

    // full seven-bit address of this slave
    assign own_addr = {SLV_ADDR_MSB, SLAVE_OFFSET};
    assign byte_done = bit_cnt_reg == BYTE_BITS;
    // a data byte of a write is handed to the buffer on its ack decision
    assign wr_push = (state_reg == ST_RX) && byte_done && scl_fall
        && (idx_reg == IDX_DATA) && wr_ready;

    ////////////////////////////////////////////////////////////////////////
    // protocol state machine; sleep pin deliberately has no effect here
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            idx_reg <= IDX_SLAVE;
            rw_reg <= DIR_WRITE;
            SDA_OE <= 1'b0;
            tx_reg <= 8'h00;
        end
        else if (!strap_done_reg || SPI_SELECT)
        begin
            state_reg <= ST_IDLE;
            SDA_OE <= 1'b0;
        end
        else if (start_ev)
        begin
            state_reg <= ST_RX;
            bit_cnt_reg <= 4'h0;
            idx_reg <= IDX_SLAVE;
            SDA_OE <= 1'b0;
        end
        else if (stop_ev)
        begin
            state_reg <= ST_IDLE;
            SDA_OE <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE, ST_WAIT:
                    SDA_OE <= 1'b0;
                ST_RX:
                    if (scl_rise && !byte_done)
                    begin
                        sh_reg <= {sh_reg[6:0], sda_f};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    else if (scl_fall && byte_done)
                    begin
                        bit_cnt_reg <= 4'h0;
                        if (idx_reg == IDX_SLAVE && sh_reg[7:1] != own_addr)
                            state_reg <= ST_WAIT;
                        else if (idx_reg == IDX_DATA && !wr_ready)
                            state_reg <= ST_WAIT;
                        else
                        begin
                            state_reg <= ST_ACK;
                            SDA_OE <= 1'b1;
                            if (idx_reg == IDX_SLAVE)
                                rw_reg <= sh_reg[0];
                            if (idx_reg != IDX_DATA)
                                idx_reg <= idx_reg + 2'h1;
                        end
                    end
                ST_ACK:
                    if (scl_fall)
                    begin
                        if (rw_reg == DIR_READ)
                        begin
                            state_reg <= ST_TX;
                            SDA_OE <= ~rd_reg[7];
                            tx_reg <= {rd_reg[6:0], 1'b0};
                            bit_cnt_reg <= 4'h1;
                        end
                        else
                        begin
                            state_reg <= ST_RX;
                            SDA_OE <= 1'b0;
                        end
                    end
                ST_TX:
                    if (scl_fall)
                    begin
                        if (byte_done)
                        begin
                            state_reg <= ST_RACK;
                            SDA_OE <= 1'b0;
                        end
                        else
                        begin
                            SDA_OE <= ~tx_reg[7];
                            tx_reg <= {tx_reg[6:0], 1'b0};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                    end
                ST_RACK:
                    if (scl_rise)
                        rw_reg <= sda_f ? DIR_WRITE : DIR_READ;
                    else if (scl_fall)
                    begin
                        if (rw_reg == DIR_READ)
                        begin
                            state_reg <= ST_TX;
                            SDA_OE <= ~rd_reg[7];
                            tx_reg <= {rd_reg[6:0], 1'b0};
                            bit_cnt_reg <= 4'h1;
                        end
                        else
                            state_reg <= ST_WAIT;
                    end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register address pointer: loaded high then low, stepped per data byte
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            addr_reg <= ADDR_RESET;
        else if (state_reg == ST_RX && byte_done && scl_fall
            && idx_reg == IDX_ADDR_HI)
            addr_reg <= {sh_reg, addr_reg[7:0]};
        else if (state_reg == ST_RX && byte_done && scl_fall
            && idx_reg == IDX_ADDR_LO)
            addr_reg <= {addr_reg[15:8], sh_reg};
        else if (wr_push || REG_RD_REQ)
            addr_reg <= addr_reg + ADDR_STEP;
    end

    // read request on each ninth clock rise of a read, also when the master refuses and no further byte follows
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            REG_RD_REQ <= 1'b0;
            REG_RD_ADDR <= ADDR_RESET;
            rd_reg <= 8'h00;
        end
        else
        begin
            REG_RD_REQ <= ((state_reg == ST_ACK && rw_reg == DIR_READ)
                || (state_reg == ST_RACK && rw_reg == DIR_READ))
                && scl_rise;
            REG_RD_ADDR <= addr_reg;
            if (REG_RD_VALID)
                rd_reg <= REG_RD_DATA;
        end
    end

    // open-drain data line only ever pulls low
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            SDA_OUT <= 1'b0;
        else
            SDA_OUT <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // write words pass a two-entry buffer so a stalled port loses nothing
    sps_wbuf #(
        .WIDTH(REG_AW + REG_DW)
    ) u_wbuf (
        .clk(CLOCK),
        .rst(RST),
        .in_valid(wr_push),
        .in_ready(wr_ready),
        .in_data({addr_reg, sh_reg}),
        .out_valid(REG_WR_VALID),
        .out_ready(REG_WR_READY),
        .out_data({REG_WR_ADDR, REG_WR_DATA})
    );

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    AST_SPI_SILENT: assert property (SPI_SELECT |-> !SDA_OE)
        else $error("data line driven in SPI mode");
    AST_ADDR_MATCH: assert property (
        (state_reg == ST_ACK && idx_reg == IDX_ADDR_HI)
        |-> sh_reg[7:4] == SLV_ADDR_MSB)
        else $error("acknowledged a foreign address");
    AST_STRAP_OFFSET: assert property (
        $rose(strap_done_reg) |-> SLAVE_OFFSET == $past(offset_next))
        else $error("strap offset captured wrongly");
    AST_CHANGE_LOW: assert property ($changed(SDA_OE) |-> !scl_f)
        else $error("data line moved while clock high");
    AST_START: assert property (start_ev && strap_done_reg && !SPI_SELECT
        |=> state_reg == ST_RX && bit_cnt_reg == 4'h0 && idx_reg == IDX_SLAVE)
        else $error("start not taken");
    AST_STOP: assert property (stop_ev && !start_ev
        |=> state_reg == ST_IDLE && !SDA_OE)
        else $error("stop not taken");
    AST_BITS: assert property (bit_cnt_reg <= BYTE_BITS)
        else $error("byte longer than eight bits");
    AST_ACK_NINTH: assert property (
        (state_reg == ST_ACK && scl_rise) |-> SDA_OE)
        else $error("ack not driven on ninth clock");
    AST_NACK_FREE: assert property (state_reg == ST_RACK |-> !SDA_OE)
        else $error("data line held during master ack");
    AST_ADDR_HI: assert property (
        (state_reg == ST_RX && byte_done && scl_fall && idx_reg == IDX_ADDR_HI
        && !start_ev && !stop_ev) |=> addr_reg[15:8] == $past(sh_reg))
        else $error("high address byte not loaded");
    AST_STEP: assert property (wr_push |=> addr_reg == $past(addr_reg) + ADDR_STEP)
        else $error("address did not step");
endmodule

// [tb/sps_i2c_master.sv]
// two-wire bus master model: drives the clock and the open-drain data line
`timescale 1ns/100ps
module sps_i2c_master (
    // sampling clock and wire level
    input wire logic clk,
    input wire logic sda_in,
    // driven lines, high means released
    output logic scl,
    output logic sda_drv
);
    int q = 63;
    // idle bus: both lines released, clock stands still
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // one quarter of a bus bit
    task automatic wait_q();
        repeat (q) @(posedge clk);
    endtask
    // start or repeated start: data falls while clock high
    task automatic start();
        wait_q();
        sda_drv <= 1'b1;
        wait_q();
        scl <= 1'b1;
        wait_q();
        sda_drv <= 1'b0;
        wait_q();
        scl <= 1'b0;
    endtask
    // stop: data rises while clock high
    task automatic stop();
        wait_q();
        sda_drv <= 1'b0;
        wait_q();
        scl <= 1'b1;
        wait_q();
        sda_drv <= 1'b1;
        wait_q();
    endtask
    // one bit: data set in clock low, sampled twice in clock high
    task automatic xfer_bit(input logic b, output logic r, output logic st);
        wait_q();
        sda_drv <= b;
        wait_q();
        scl <= 1'b1;
        wait_q();
        r = sda_in;
        wait_q();
        st = (sda_in === r);
        scl <= 1'b0;
    endtask
    // eight bits msb first, then the acknowledge bit
    task automatic xfer_byte(input logic [7:0] d, input logic ack_lvl,
        output logic [7:0] r, output logic ack, output logic st);
        logic s;
        st = 1'b1;
        for (int i = 7; i >= 0; i--)
        begin
            xfer_bit(d[i], r[i], s);
            st &= s;
        end
        xfer_bit(ack_lvl, ack, s);
        st &= s;
    endtask
endmodule

// [tb/tb.sv]
// self-checking bench for the strap-selected two-wire register slave
`timescale 1ns/100ps
module tb;
    import sps_pkg::*;
    // pins and bench state
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [1:0] sel_up = LVL_LOW;
    logic [1:0] sel_lo = LVL_LOW;
    logic sleep_n = 1'b1;
    logic wr_ready = 1'b0;
    logic rd_valid = 1'b0;
    logic [7:0] rd_data = 8'h00;
    logic ready_en = 1'b1;
    logic scl, sda_drv, sda_out, sda_oe, spi_sel, wr_valid, rd_req, ack, st;
    logic [2:0] offset;
    logic [15:0] wr_addr, rd_addr, base;
    logic [7:0] wr_data, r8;
    logic [6:0] slv;
    logic [31:0] seed = 32'h00000053;
    logic [23:0] got_q[$];
    logic [23:0] exp_q[$];
    int errors = 0;
    int check_count = 0;
    wire sda;
    // open-drain wire with pull-up
    assign sda = sda_drv & (sda_oe ? sda_out : 1'b1);
    always #5 clock = ~clock;
    sps_serial_port i_dut (.CLOCK(clock), .RST(rst), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .PORT_SELECT_UPPER(sel_up),
        .PORT_SELECT_LOWER(sel_lo), .CHIP_SLEEP_N(sleep_n), .SPI_SELECT(spi_sel),
        .SLAVE_OFFSET(offset), .REG_WR_VALID(wr_valid), .REG_WR_READY(wr_ready),
        .REG_WR_ADDR(wr_addr), .REG_WR_DATA(wr_data), .REG_RD_REQ(rd_req),
        .REG_RD_ADDR(rd_addr), .REG_RD_VALID(rd_valid), .REG_RD_DATA(rd_data));
    sps_i2c_master i_master (.clk(clock), .sda_in(sda), .scl(scl), .sda_drv(sda_drv));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] rd_fn(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3C;
    endfunction
    task automatic check_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t: bit %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t: value %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic end_test(input string name);
        $display("test %s done, mismatches %0d", name, errors);
    endtask
    task automatic reset_dut();
        @(posedge clock);
        rst <= 1'b1;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        repeat (12) @(posedge clock);
    endtask
    task automatic wbyte(input logic [7:0] d, input logic exp_lvl);
        i_master.xfer_byte(d, 1'b1, r8, ack, st);
        check_bit(ack, exp_lvl);
    endtask
    task automatic header(input logic [6:0] a, input logic dir, input logic exp_lvl);
        i_master.start();
        wbyte({a, dir}, exp_lvl);
    endtask
    task automatic put_ptr(input logic [15:0] a);
        header(slv, DIR_WRITE, 1'b0);
        wbyte(a[15:8], 1'b0);
        wbyte(a[7:0], 1'b0);
    endtask
    // data bytes at consecutive addresses, last one refused when nack_last
    task automatic write_run(input logic [15:0] a, input int n, input logic nack_last);
        logic [7:0] d;
        put_ptr(a);
        for (int i = 0; i < n; i++)
        begin
            d = 8'(rnd());
            wbyte(d, nack_last && i == n - 1);
            if (!(nack_last && i == n - 1))
                exp_q.push_back({a + 16'(i), d});
        end
        i_master.stop();
    endtask
    task automatic drain_check();
        for (int k = 0; k < 200 && got_q.size() < exp_q.size(); k++)
            @(posedge clock);
        repeat (20) @(posedge clock);
        check_val(24'(got_q.size()), 24'(exp_q.size()));
        foreach (exp_q[i])
            if (i < got_q.size())
                check_val(got_q[i], exp_q[i]);
        got_q.delete();
        exp_q.delete();
    endtask
    // register side: stalling write sink and delayed read source
    always @(posedge clock)
        wr_ready <= ready_en && rnd() > 32'h7FFFFFFF;
    always @(posedge clock)
        if (wr_valid === 1'b1 && wr_ready === 1'b1)
            got_q.push_back({wr_addr, wr_data});
    initial
    begin
        logic [15:0] a;
        forever
        begin
            @(posedge clock);
            if (rd_req === 1'b1)
            begin
                a = rd_addr;
                repeat (1 + int'(rnd() % 16)) @(posedge clock);
                rd_valid <= 1'b1;
                rd_data <= rd_fn(a);
                @(posedge clock);
                rd_valid <= 1'b0;
            end
        end
    end
    // hang guard
    initial
    begin
        #1300000;
        errors++;
        final_report();
    end
    // test sequence
    initial
    begin
        for (int u = 0; u < 3; u++)
            for (int l = 0; l < 3; l++)
            begin
                sel_up <= 2'(u);
                sel_lo <= 2'(l);
                reset_dut();
                check_bit(spi_sel, u == 2 && l == 2);
                if (!(u == 2 && l == 2))
                    check_val(24'(offset), 24'(u * 3 + l));
            end
        header({SLV_ADDR_MSB, 3'h0}, DIR_WRITE, 1'b1);
        i_master.stop();
        end_test("straps");
        sel_up <= LVL_OPEN;
        sel_lo <= LVL_HIGH;
        reset_dut();
        slv = {SLV_ADDR_MSB, 3'h5};
        sleep_n <= 1'b0;
        write_run(16'hFFFE, 3, 1'b0);
        drain_check();
        sleep_n <= 1'b1;
        end_test("write");
        header({SLV_ADDR_MSB, 3'h4}, DIR_WRITE, 1'b1);
        i_master.stop();
        end_test("address");
        ready_en <= 1'b0;
        write_run(16'(rnd()), 3, 1'b1);
        check_bit(wr_valid, 1'b1);
        ready_en <= 1'b1;
        drain_check();
        end_test("full");
        put_ptr(16'(rnd()));
        for (int i = 0; i < 4; i++)
            i_master.xfer_bit(1'b0, ack, st);
        i_master.stop();
        drain_check();
        end_test("partial");
        base = 16'(rnd());
        put_ptr(base);
        header(slv, DIR_READ, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            i_master.xfer_byte(8'hFF, i == 2, r8, ack, st);
            check_val(24'(r8), 24'(rd_fn(base + 16'(i))));
            check_bit(st, 1'b1);
        end
        i_master.wait_q();
        check_bit(sda_oe, 1'b0);
        i_master.stop();
        end_test("read");
        i_master.q = 250;
        write_run(16'(rnd()), 1, 1'b0);
        drain_check();
        end_test("standard");
        final_report();
    end
endmodule
